// [lpw_sequencer.sv]
// Suspend entry and wake-up sequencer of the low-power block
// Summary of operation
// - Suspend entry locks writes, state stays unchanged
// - Optional set/reset on wake, before unlock
// - Whole wake sequence timed by one clock
// - Select internal oscillator or startup clock setting
// - Oscillator stopped while suspended when it is the wake clock
// - Config clock pin only in slave persist
// - Outputs released after output release count
// - Writes unlocked after write unlock count
// - Test and done pins stay functional
// - Request high suspends, falling edge wakes
// - Feature disabled ignores sleep request entirely
// - Selectable glitch filter on sleep request
// - Sleep request never affects configuration
// - Request high at config end suspends immediately
// - Status pin low asleep, high active
// - Feature disabled makes status pin user I/O
// - Status pin open-drain unless active drive
// - Wake continues only once status sensed high
// - Set/reset before status high and counters
// - Filter adds about 300 ns rising delay
module lpw_sequencer
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        config_done,
    input  wire logic        feature_enable,
    input  wire logic        filter_enable,
    input  wire logic        active_drive,
    input  wire logic        wake_setreset_enable,
    input  wire logic        wake_clock_select,
    input  wire logic [1:0]  startup_clock_setting,
    input  wire logic        slave_mode,
    input  wire logic        persist_enable,
    input  wire logic [10:0] output_release_count,
    input  wire logic [10:0] write_unlock_count,
    input  wire logic        suspend_pin,
    input  wire logic        cclk_pin,
    input  wire logic        tck_pin,
    input  wire logic        user_clk,
    input  wire logic        active_status_in,
    output logic             active_status_out,
    output logic             active_status_oe_n,
    input  wire logic        gpio_out,
    input  wire logic        gpio_oe_n,
    output logic             output_hold,
    output logic             write_lock,
    output logic             setreset_pulse,
    output logic             osc_run,
    output logic             done_pin,
    output logic             suspended
);

    // Raw asynchronous inputs gathered for synchronising
    logic [lpw_pkg::NSYNC-1:0]  async_in;
    // First synchroniser stage
    logic [lpw_pkg::NSYNC-1:0]  meta_ff;
    // Second synchroniser stage
    logic [lpw_pkg::NSYNC-1:0]  sync_ff;
    // Delayed copy for edge detection
    logic [lpw_pkg::NSYNC-1:0]  dly_ff;
    // Rising edges of the synchronised inputs
    logic [lpw_pkg::NSYNC-1:0]  rise;

    // Filtered sleep request
    logic                       susp_f;
    // Effective sleep request after feature gate
    logic                       susp_req;

    // Oscillator divider and tick
    logic [lpw_pkg::OSC_DIV_W-1:0] div_ff;
    logic                       osc_tick;
    // Selected wake clock tick
    logic                       wake_tick;
    // Selected source uses the internal oscillator
    logic                       use_osc;

    // Sequencer state
    lpw_pkg::lpw_state_e        state_ff;
    lpw_pkg::lpw_state_e        nxt_state;

    // Independent release counters
    logic [lpw_pkg::CNT_W-1:0]  rel_cnt_ff;
    logic [lpw_pkg::CNT_W-1:0]  unl_cnt_ff;
    // Counters reach their programmed count on this tick
    logic                       rel_hit;
    logic                       unl_hit;

    // Output flops
    logic                       stat_out_ff;
    logic                       stat_oe_n_ff;
    logic                       hold_ff;
    logic                       lock_ff;
    logic                       gsr_ff;
    logic                       osc_run_ff;
    logic                       done_ff;
    logic                       susp_ff;

    assign async_in = {config_done, user_clk, tck_pin, cclk_pin, active_status_in, suspend_pin};

    // Two-flop synchroniser per pin input
    genvar gi;
    generate
        for (gi = 0; gi < lpw_pkg::NSYNC; gi++)
        begin : g_sync
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                    dly_ff[gi]  <= 1'b0;
                end
                else
                begin
                    meta_ff[gi] <= async_in[gi];
                    sync_ff[gi] <= meta_ff[gi];
                    dly_ff[gi]  <= sync_ff[gi];
                end
            end
            assign rise[gi] = sync_ff[gi] & ~dly_ff[gi];
        end
    endgenerate

    // Glitch filter on the sleep request
    lpw_glitch_filter u_filt
    (
        .clk    (clk),
        .rstn   (rstn),
        .bypass (!filter_enable),
        .din    (sync_ff[lpw_pkg::SY_SUSP]),
        .dout   (susp_f)
    );

    // Request only counts with the feature on
    assign susp_req = feature_enable & susp_f;

    // Internal oscillator modelled as a tick divider
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_ff <= '0;
        end
        else if (!osc_run_ff)
        begin
            // Held still while asleep
            div_ff <= '0;
        end
        else if (div_ff == lpw_pkg::OSC_DIV_W'(lpw_pkg::OSC_DIV - 1))
        begin
            div_ff <= '0;
        end
        else
        begin
            div_ff <= div_ff + 1'b1;
        end
    end

    assign osc_tick = osc_run_ff && (div_ff == lpw_pkg::OSC_DIV_W'(lpw_pkg::OSC_DIV - 1));

    // Wake clock source selection
    always_comb
    begin
        use_osc   = 1'b1;
        wake_tick = osc_tick;
        if (wake_clock_select == lpw_pkg::LPW_WCS_STARTUP)
        begin
            unique case (lpw_pkg::lpw_scs_e'(startup_clock_setting))
                lpw_pkg::LPW_SCS_CCLK:
                begin
                    // Pin clock only in slave mode with persist
                    if (slave_mode && persist_enable)
                    begin
                        use_osc   = 1'b0;
                        wake_tick = rise[lpw_pkg::SY_CCLK];
                    end
                end
                lpw_pkg::LPW_SCS_TCK:
                begin
                    // Test clock must keep running
                    use_osc   = 1'b0;
                    wake_tick = rise[lpw_pkg::SY_TCK];
                end
                lpw_pkg::LPW_SCS_USER:
                begin
                    // User clock from unregistered logic
                    use_osc   = 1'b0;
                    wake_tick = rise[lpw_pkg::SY_UCLK];
                end
                lpw_pkg::LPW_SCS_SPARE:
                begin
                    // Unused code falls back to oscillator
                    use_osc   = 1'b1;
                    wake_tick = osc_tick;
                end
            endcase
        end
    end

    // Counter hits; a count of zero acts as one
    assign rel_hit = wake_tick && ((rel_cnt_ff + 1'b1) >= output_release_count);
    assign unl_hit = wake_tick && ((unl_cnt_ff + 1'b1) >= write_unlock_count);

    // Next state of the sequencer
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            lpw_pkg::LPW_ST_CONFIG:
            begin
                // Request is not looked at until configuration ends
                if (sync_ff[lpw_pkg::SY_DONE])
                begin
                    nxt_state = susp_req ? lpw_pkg::LPW_ST_SUSPEND
                                         : lpw_pkg::LPW_ST_ACTIVE;
                end
            end
            lpw_pkg::LPW_ST_ACTIVE:
            begin
                if (susp_req)
                begin
                    nxt_state = lpw_pkg::LPW_ST_SUSPEND;
                end
            end
            lpw_pkg::LPW_ST_SUSPEND:
            begin
                // Falling request starts the wake sequence
                if (!susp_req)
                begin
                    nxt_state = wake_setreset_enable ? lpw_pkg::LPW_ST_SETRESET
                                                     : lpw_pkg::LPW_ST_WAIT_ACTIVE_STATUS_PIN;
                end
            end
            lpw_pkg::LPW_ST_SETRESET:
            begin
                // Set/reset spans one wake clock tick
                if (susp_req)
                begin
                    nxt_state = lpw_pkg::LPW_ST_SUSPEND;
                end
                else if (wake_tick)
                begin
                    nxt_state = lpw_pkg::LPW_ST_WAIT_ACTIVE_STATUS_PIN;
                end
            end
            lpw_pkg::LPW_ST_WAIT_ACTIVE_STATUS_PIN:
            begin
                // Stay until the status line really reads high
                if (susp_req)
                begin
                    nxt_state = lpw_pkg::LPW_ST_SUSPEND;
                end
                else if (sync_ff[lpw_pkg::SY_STAT])
                begin
                    nxt_state = lpw_pkg::LPW_ST_RELEASE;
                end
            end
            lpw_pkg::LPW_ST_RELEASE:
            begin
                if (susp_req)
                begin
                    nxt_state = lpw_pkg::LPW_ST_SUSPEND;
                end
                else if (!hold_ff && !lock_ff)
                begin
                    nxt_state = lpw_pkg::LPW_ST_ACTIVE;
                end
            end
            default:
            begin
                nxt_state = lpw_pkg::LPW_ST_CONFIG;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= lpw_pkg::LPW_ST_CONFIG;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Release counters, cleared outside the release phase
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rel_cnt_ff <= '0;
            unl_cnt_ff <= '0;
        end
        else if (state_ff != lpw_pkg::LPW_ST_RELEASE)
        begin
            rel_cnt_ff <= '0;
            unl_cnt_ff <= '0;
        end
        else if (wake_tick)
        begin
            // Both count the same ticks, each on its own
            if (hold_ff)
            begin
                rel_cnt_ff <= rel_cnt_ff + 1'b1;
            end
            if (lock_ff)
            begin
                unl_cnt_ff <= unl_cnt_ff + 1'b1;
            end
        end
    end

    // Output hold control
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hold_ff <= lpw_pkg::OUTPUT_HOLD_RST;
        end
        else if (nxt_state == lpw_pkg::LPW_ST_SUSPEND)
        begin
            hold_ff <= 1'b1;
        end
        else if (state_ff == lpw_pkg::LPW_ST_CONFIG && nxt_state == lpw_pkg::LPW_ST_ACTIVE)
        begin
            hold_ff <= 1'b0;
        end
        else if (state_ff == lpw_pkg::LPW_ST_RELEASE && rel_hit)
        begin
            hold_ff <= 1'b0;
        end
    end

    // Write lock control
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lock_ff <= lpw_pkg::WRITE_LOCK_RST;
        end
        else if (nxt_state == lpw_pkg::LPW_ST_SUSPEND)
        begin
            // Freeze all clocked state on entry
            lock_ff <= 1'b1;
        end
        else if (state_ff == lpw_pkg::LPW_ST_CONFIG && nxt_state == lpw_pkg::LPW_ST_ACTIVE)
        begin
            lock_ff <= 1'b0;
        end
        else if (state_ff == lpw_pkg::LPW_ST_RELEASE && unl_hit)
        begin
            // Set/reset has already finished here
            lock_ff <= 1'b0;
        end
    end

    // Global set/reset pulse during the set/reset step
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gsr_ff <= 1'b0;
        end
        else
        begin
            gsr_ff <= (nxt_state == lpw_pkg::LPW_ST_SETRESET);
        end
    end

    // Oscillator runs except while asleep with it as the wake clock
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            osc_run_ff <= 1'b1;
        end
        else
        begin
            osc_run_ff <= (nxt_state != lpw_pkg::LPW_ST_SUSPEND) || !use_osc;
        end
    end

    // Status pin drive
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stat_out_ff  <= 1'b0;
            stat_oe_n_ff <= 1'b1;
        end
        else if (!feature_enable)
        begin
            // Pin belongs to the user design
            stat_out_ff  <= gpio_out;
            stat_oe_n_ff <= gpio_oe_n;
        end
        else
        begin
            unique case (nxt_state)
                lpw_pkg::LPW_ST_SUSPEND, lpw_pkg::LPW_ST_SETRESET:
                begin
                    // Low while asleep or still resetting
                    stat_out_ff  <= 1'b0;
                    stat_oe_n_ff <= 1'b0;
                end
                lpw_pkg::LPW_ST_CONFIG:
                begin
                    stat_out_ff  <= 1'b0;
                    stat_oe_n_ff <= 1'b1;
                end
                default:
                begin
                    // High: driven, or released to the pull-up
                    stat_out_ff  <= active_drive;
                    stat_oe_n_ff <= !active_drive;
                end
            endcase
        end
    end

    // Done pin and sleep indication
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            done_ff <= 1'b0;
            susp_ff <= 1'b0;
        end
        else
        begin
            // Done follows configuration regardless of sleep
            done_ff <= sync_ff[lpw_pkg::SY_DONE];
            susp_ff <= (nxt_state == lpw_pkg::LPW_ST_SUSPEND);
        end
    end

    assign active_status_out  = stat_out_ff;
    assign active_status_oe_n = stat_oe_n_ff;
    assign output_hold        = hold_ff;
    assign write_lock         = lock_ff;
    assign setreset_pulse     = gsr_ff;
    assign osc_run            = osc_run_ff;
    assign done_pin           = done_ff;
    assign suspended          = susp_ff;

endmodule

// [lpw_pkg.sv]
// Package with constants and types for the suspend and wake sequencer
package lpw_pkg;

    // System clock rate
    localparam int unsigned CLK_HZ      = 200_000_000;
    // Internal oscillator rate while running
    localparam int unsigned OSC_HZ      = 50_000_000;
    // System cycles per oscillator tick
    localparam int unsigned OSC_DIV     = CLK_HZ / OSC_HZ;
    // Divider counter width
    localparam int unsigned OSC_DIV_W   = 2;

    // Typical glitch filter delay in ns
    localparam int unsigned FILT_NS     = 300;
    // Filter delay in cycles, rounded up
    localparam int unsigned FILT_CYC    = (FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Filter counter width
    localparam int unsigned FILT_W      = 7;

    // Width of the release counts, 1 to 1024
    localparam int unsigned CNT_W       = 11;
    // Default output release count
    localparam logic [10:0] OUT_REL_DEF = 11'h004;
    // Default write unlock count
    localparam logic [10:0] WR_UNL_DEF  = 11'h005;

    // Number of pin inputs passing the synchroniser
    localparam int unsigned NSYNC       = 6;
    // Bit positions in the synchronised vector
    localparam int unsigned SY_SUSP     = 0;
    localparam int unsigned SY_STAT     = 1;
    localparam int unsigned SY_CCLK     = 2;
    localparam int unsigned SY_TCK      = 3;
    localparam int unsigned SY_UCLK     = 4;
    localparam int unsigned SY_DONE     = 5;

    // Reset values of the pin-facing flops
    localparam logic WRITE_LOCK_RST     = 1'b1;
    localparam logic OUTPUT_HOLD_RST    = 1'b1;

    // Wake clock select choices
    typedef enum logic {
        LPW_WCS_INTERNAL,
        LPW_WCS_STARTUP
    } lpw_wcs_e;

    // Startup clock setting choices
    typedef enum logic [1:0] {
        LPW_SCS_CCLK,
        LPW_SCS_TCK,
        LPW_SCS_USER,
        LPW_SCS_SPARE
    } lpw_scs_e;

    // Sequencer states
    typedef enum logic [2:0] {
        LPW_ST_CONFIG,
        LPW_ST_ACTIVE,
        LPW_ST_SUSPEND,
        LPW_ST_SETRESET,
        LPW_ST_WAIT_ACTIVE_STATUS_PIN,
        LPW_ST_RELEASE
    } lpw_state_e;

endpackage

// [lpw_glitch_filter.sv]
// Glitch filter on the synchronised sleep request
module lpw_glitch_filter
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic bypass,
    input  wire logic din,
    output logic      dout
);

    // Cycles the request has stood high
    logic [lpw_pkg::FILT_W-1:0] cnt_ff;
    // Filtered level
    logic                       dout_ff;

    // Rising edges must persist, falling edges pass at once
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_ff  <= '0;
            dout_ff <= 1'b0;
        end
        else if (bypass || !din)
        begin
            // Bypass or low level: follow input directly
            cnt_ff  <= '0;
            dout_ff <= din;
        end
        else if (!dout_ff)
        begin
            // High but not yet accepted
            if (cnt_ff == lpw_pkg::FILT_W'(lpw_pkg::FILT_CYC - 1))
            begin
                dout_ff <= 1'b1;
            end
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign dout = dout_ff;

endmodule

// [lpw_seq_monitor.sv]
// Port checker for suspend entry and wake sequencing
module lpw_seq_monitor
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        feature_enable,
    input wire logic        filter_enable,
    input wire logic        active_drive,
    input wire logic        wake_setreset_enable,
    input wire logic        wake_clock_select,
    input wire logic [10:0] output_release_count,
    input wire logic [10:0] write_unlock_count,
    input wire logic        suspend_pin,
    input wire logic        active_status_in,
    input wire logic        active_status_out,
    input wire logic        active_status_oe_n,
    input wire logic        output_hold,
    input wire logic        write_lock,
    input wire logic        setreset_pulse,
    input wire logic        osc_run,
    input wire logic        done_pin,
    input wire logic        suspended
);
    timeunit 1ns;
    timeprecision 100ps;
    // One clock domain, checks off during reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Suspend always carries both locks
    lock_hold_a: assert property (suspended |-> write_lock && output_hold)
        else $error("suspend without lock or hold");
    // No set/reset pulse when option off
    setreset_off_a: assert property (!wake_setreset_enable |-> !setreset_pulse)
        else $error("set/reset pulse while disabled");
    // Pulse lies before status high and before releases
    setreset_order_a: assert property (setreset_pulse |-> write_lock && output_hold && !active_status_in)
        else $error("set/reset pulse out of order");
    // Oscillator halted while asleep on it
    osc_stop_a: assert property (suspended && $past(suspended) && !wake_clock_select |-> !osc_run)
        else $error("oscillator runs in suspend");
    // Status driven low while asleep
    status_low_a: assert property (suspended |-> !active_status_oe_n && !active_status_out)
        else $error("status not low in suspend");
    // Disabled feature never suspends
    ignore_req_a: assert property (!feature_enable |-> !suspended)
        else $error("suspend with feature off");
    // Open-drain status never drives high
    open_drain_a: assert property (feature_enable && $past(feature_enable) && !active_drive && !$past(active_drive)
        |-> active_status_oe_n || !active_status_out)
        else $error("open-drain status driven high");
    // Filtered request must have been high a long while
    filter_delay_a: assert property ($rose(suspended) && filter_enable |-> $past(suspend_pin, 50))
        else $error("filtered request passed too soon");
    // Outputs only released once status was seen high
    sense_high_a: assert property ($fell(output_hold) && feature_enable |-> $past(active_status_in, 2))
        else $error("release without status high");
    // Earlier output count frees outputs no later than writes
    release_order_a: assert property ($fell(write_lock) && (output_release_count <= write_unlock_count)
        |-> !output_hold)
        else $error("writes unlocked before outputs");
    // Main scenarios reached
    cover property ($rose(suspended));
    cover property ($fell(write_lock));
    cover property ($rose(setreset_pulse));
endmodule

bind lpw_sequencer lpw_seq_monitor mon (.*);

// [lpw_pm_model.sv]
// Model of the external power manager: request, status line, wake clock
module lpw_pm_model
(
    input  wire logic req,
    input  wire logic hold_low,
    input  wire logic run_clk,
    input  wire logic status_out,
    input  wire logic status_oe_n,
    output logic      suspend_pin,
    output logic      status_level,
    output logic      wake_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    // Request follows the command, low in normal use
    assign suspend_pin = req;
    // Pulled-up line, device drive wins, controller may pull low
    assign status_level = !status_oe_n ? status_out : !hold_low;
    // Free generator, no frozen register behind it; low outside wake
    always #20 wake_clk = run_clk && !wake_clk;
endmodule

// [tb_top.sv]
// Self-checking bench for the suspend and wake sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // Design inputs and partner commands
    logic        clk, rstn, config_done, feature_enable, filter_enable, active_drive;
    logic        wake_setreset_enable, wake_clock_select, slave_mode, persist_enable;
    logic [1:0]  startup_clock_setting;
    logic [10:0] output_release_count, write_unlock_count;
    logic        req, hold_low, wclk_run, gpio_out, gpio_oe_n;
    // Design outputs and partner lines
    logic        suspend_pin, cclk_pin, tck_pin, user_clk, active_status_in, active_status_out;
    logic        active_status_oe_n, output_hold, write_lock, setreset_pulse, osc_run, done_pin, suspended;
    int          err_count = 0, n_compared = 0, t, w;
    // Startup setting and tick spacing per clock choice
    int          scs_tbl [6] = '{0, 0, 1, 2, 3, 0};
    int          div_tbl [6] = '{lpw_pkg::OSC_DIV, 8, 8, 8, lpw_pkg::OSC_DIV, lpw_pkg::OSC_DIV};

    // 200 MHz clock
    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    // One partner clock feeds every external source
    assign tck_pin = cclk_pin;
    assign user_clk = cclk_pin;

    lpw_sequencer dut (.*);
    lpw_pm_model pm (.req(req), .hold_low(hold_low), .run_clk(wclk_run), .status_out(active_status_out),
        .status_oe_n(active_status_oe_n), .suspend_pin(suspend_pin), .status_level(active_status_in),
        .wake_clk(cclk_pin));

    // Verdict and end of run
    task automatic print_verdict();
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Single-bit compare
    task automatic check_bit(input logic e, input logic a);
        n_compared++;
        if (a !== e)
        begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h act=%h", $time, e, a);
        end
    endtask
    // Cycle count compare against a window
    task automatic check_rng(input int lo, input int hi, input int a);
        n_compared++;
        if (a < lo || a > hi)
        begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h..%h act=%h", $time, lo, hi, a);
        end
    endtask
    // Observed output picked by index
    function automatic logic sig(input int s);
        case (s)
            0: return suspended;
            1: return output_hold;
            2: return write_lock;
            3: return active_status_in;
            default: return setreset_pulse;
        endcase
    endfunction
    // Bounded wait for a level, counting cycles
    task automatic wait_sig(input int s, input logic v, output int n);
        n = 0;
        while (sig(s) !== v)
        begin
            @(posedge clk);
            #1;
            n++;
            if (n > 20000)
            begin
                err_count++;
                print_verdict();
            end
        end
    endtask
    // Raise request with given counts, check entry latency, write lock, status and done
    task automatic enter(input int lo, input int hi, input int n, input int m);
        int d;
        output_release_count = n[10:0];
        write_unlock_count = m[10:0];
        req = 1'b1;
        wait_sig(0, 1'b1, d);
        check_rng(lo, hi, d);
        check_bit(1'b1, write_lock);
        check_bit(1'b0, active_status_in);
        check_bit(1'b1, done_pin);
    endtask
    // Drop request, time output release and write unlock
    task automatic wake_run(input int n, input int m, input int d);
        int t0;
        int t1;
        int t2;
        wclk_run = 1'b1;
        req = 1'b0;
        wait_sig(3, 1'b1, t0);
        wait_sig(1, 1'b0, t1);
        wait_sig(2, 1'b0, t2);
        check_rng((n - 1) * d, n * d + 12, t1);
        check_rng((m - n) * d, (m - n) * d, t2);
        check_bit(1'b0, suspended);
        wclk_run = 1'b0;
    endtask

    // Main sequence
    initial
    begin
        {rstn, config_done, filter_enable, active_drive, wake_setreset_enable, wake_clock_select} = '0;
        {startup_clock_setting, hold_low, wclk_run, gpio_out} = '0;
        {feature_enable, slave_mode, persist_enable, req, gpio_oe_n} = '1;
        output_release_count = 11'h004;
        write_unlock_count = 11'h005;
        repeat (20) @(posedge clk);
        #1 rstn = 1'b1;
        check_bit(1'b1, write_lock);
        repeat (5) @(posedge clk);
        #1 config_done = 1'b1;
        wait_sig(0, 1'b1, t);
        check_bit(1'b1, done_pin);
        check_bit(1'b0, active_status_in);
        check_bit(1'b0, osc_run);
        wake_run(4, 5, lpw_pkg::OSC_DIV);
        // Every wake clock choice, fallbacks included
        for (int i = 0; i < 6; i++)
        begin
            wake_clock_select = (i > 0);
            startup_clock_setting = scs_tbl[i][1:0];
            slave_mode = (i != 5);
            enter(2, 7, 1 + 3 * i, 1 + 4 * i);
            wake_run(1 + 3 * i, 1 + 4 * i, div_tbl[i]);
        end
        wake_clock_select = 1'b0;
        slave_mode = 1'b1;
        enter(2, 7, 1024, 1024);
        wake_run(1024, 1024, lpw_pkg::OSC_DIV);
        // Set/reset pulse on wake
        wake_setreset_enable = 1'b1;
        enter(2, 7, 2, 3);
        req = 1'b0;
        wait_sig(4, 1'b1, t);
        check_bit(1'b1, write_lock);
        wait_sig(4, 1'b0, w);
        check_rng(lpw_pkg::OSC_DIV - 1, lpw_pkg::OSC_DIV + 1, w);
        wake_run(2, 3, lpw_pkg::OSC_DIV);
        wake_setreset_enable = 1'b0;
        // Controller holds status low to postpone wake
        hold_low = 1'b1;
        enter(2, 7, 3, 3);
        req = 1'b0;
        repeat (200) @(posedge clk);
        #1 check_bit(1'b1, write_lock);
        check_bit(1'b1, output_hold);
        hold_low = 1'b0;
        wake_run(3, 3, lpw_pkg::OSC_DIV);
        // Actively driven status
        active_drive = 1'b1;
        enter(2, 7, 1, 2);
        wake_run(1, 2, lpw_pkg::OSC_DIV);
        check_bit(1'b0, active_status_oe_n);
        check_bit(1'b1, active_status_out);
        active_drive = 1'b0;
        // Request rises again mid-release
        enter(2, 7, 40, 60);
        req = 1'b0;
        wait_sig(3, 1'b1, t);
        repeat (200) @(posedge clk);
        #1 req = 1'b1;
        wait_sig(0, 1'b1, t);
        check_rng(2, 7, t);
        check_bit(1'b1, output_hold);
        wake_run(40, 60, lpw_pkg::OSC_DIV);
        // Filter rejects a short pulse, delays a long one
        filter_enable = 1'b1;
        req = 1'b1;
        repeat (30) @(posedge clk);
        #1 req = 1'b0;
        repeat (80) @(posedge clk);
        #1 check_bit(1'b0, suspended);
        enter(58, 70, 4, 5);
        wake_run(4, 5, lpw_pkg::OSC_DIV);
        filter_enable = 1'b0;
        // Feature off: request ignored, status pin is user I/O
        feature_enable = 1'b0;
        req = 1'b1;
        gpio_out = 1'b1;
        gpio_oe_n = 1'b0;
        repeat (100) @(posedge clk);
        #1 check_bit(1'b0, suspended);
        check_bit(1'b0, write_lock);
        check_bit(1'b1, active_status_out);
        check_bit(1'b0, active_status_oe_n);
        print_verdict();
    end
endmodule
